// ---- rtl/rcause_defines.svh ----
// rcause_defines.svh: offsets, field positions, widths, timeout and vectors for the reset-cause block
// assumes inclusion by bare name from rtl/ and tb/ files
`ifndef RCAUSE_DEFINES_SVH
`define RCAUSE_DEFINES_SVH

`define ADDR_W 4
`define OFF_CAUSE 4'h0
`define OFF_CLK_CTRL 4'h1
`define OFF_IRQ_STAT 4'h2
`define OFF_IRQ_MASK 4'h3
`define OFF_EVENT 4'h4

// cause flag positions in reset_cause_reg
`define F_TRAP 0
`define F_ILLOP 1
`define F_PIN 2
`define F_SOFT 3
`define F_DOG 4
`define F_IDLE 5
`define F_SLEEP 6
`define F_POR 7
`define F_BOR 8
`define CAUSE_W 9

// clock control fields: [1:0] current source, [3:2] new source request, [4] switch request,
// [7:5] postscaler select, [8] multiplier enable, [9] clock fail seen (status)
`define CK_SRC_LO 0
`define CK_NEW_LO 2
`define CK_SW 4
`define CK_POST_LO 5
`define CK_PLL 8
`define CK_FAIL 9
`define CK_W 10

`define PC_W 24
`define VEC_RESET 24'h000000
`define VEC_CLKFAIL 24'h000004

// clock fail timeout: no reference tick for 1 us declares loss
`define FAIL_NS 1000
`define CLK_NS 8
`define FAIL_CYC ((`FAIL_NS) / (`CLK_NS))
`define FAIL_CNT_W 8
`define POST_W 3
`define POST_CNT_W 7

`endif

// ---- rtl/rcause_pkg.sv ----
// rcause_pkg: event and clock source types for the reset-cause block
// assumes nothing beyond a SystemVerilog compiler
package rcause_pkg;
    typedef enum logic [3:0] {
        EV_NONE = 4'h0,
        EV_POR = 4'h1,
        EV_BOR = 4'h2,
        EV_PIN = 4'h3,
        EV_SOFT = 4'h4,
        EV_DOG_RESET = 4'h5,
        EV_DOG_WAKE = 4'h6,
        EV_INT_WAKE = 4'h7,
        EV_CLK_FAIL = 4'h8,
        EV_TRAP = 4'h9,
        EV_ILLOP = 4'hA
    } event_t;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_IDLE = 2'b01,
        PWR_SLEEP = 2'b10
    } power_state_t;

    typedef enum logic [1:0] {
        SRC_FAST_RC = 2'b00,
        SRC_PRIMARY = 2'b01,
        SRC_SECONDARY = 2'b10,
        SRC_LOW_RC = 2'b11
    } clk_src_t;
endpackage

// ---- rtl/clk_postscale.sv ----
// clk_postscale: one-cycle enable pulse dividing the system clock by 2^sel
// assumes a single clock domain; sel may change at any time
`timescale 1ns/100ps
`include "rcause_defines.svh"
module clk_postscale (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [`POST_W-1:0] sel_i,
    output logic tick_o
);
    logic [`POST_CNT_W-1:0] cnt_reg;
    logic [`POST_CNT_W-1:0] mask;
    wire hit;

    assign mask = (`POST_CNT_W'(1) << sel_i) - `POST_CNT_W'(1);
    assign hit = ((cnt_reg & mask) == mask);

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + `POST_CNT_W'(1);
            tick_o <= hit;
        end
    end
endmodule

// ---- rtl/reset_cause_and_clock_select.sv ----
// reset_cause_and_clock_select: reset-cause flags, restart vector, clock source and fail monitor
// assumes one-cycle event pulses from core logic on clock_i; ref_clk_i and the pin are asynchronous
`timescale 1ns/100ps
`include "rcause_defines.svh"
module reset_cause_and_clock_select (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire rcause_pkg::event_t event_i,
    input wire logic event_valid_i,
    input wire rcause_pkg::power_state_t power_state_i,
    input wire logic master_clear_pin_i,
    input wire logic [`PC_W-1:0] pc_i,
    input wire logic [`PC_W-1:0] int_vector_i,
    input wire logic int_enabled_i,
    input wire rcause_pkg::clk_src_t config_src_i,
    input wire logic ref_clk_i,
    output logic [`PC_W-1:0] restart_pc_o,
    output logic restart_o,
    output logic [1:0] clk_src_o,
    output logic pll_en_o,
    output logic sys_tick_o,
    output logic clk_fail_trap_o,
    output logic irq_o
);
    import rcause_pkg::*;

    // event codes that send the core to the reset vector; the pin path is decoded on its own
    function automatic logic is_reset_code(input event_t e);
        logic hit;
        unique case (e)
            EV_POR, EV_BOR, EV_SOFT: hit = 1'b1;
            EV_DOG_RESET, EV_TRAP, EV_ILLOP: hit = 1'b1;
            EV_NONE, EV_PIN, EV_CLK_FAIL: hit = 1'b0;
            EV_DOG_WAKE, EV_INT_WAKE: hit = 1'b0;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic is_wake_code(input event_t e);
        return (e == EV_DOG_WAKE) || (e == EV_INT_WAKE);
    endfunction

    // write-one-to-clear with the hardware set winning, so an event in the clear cycle is kept
    function automatic logic [3:0] w1c_update(input logic [3:0] cur, input logic [3:0] clr, input logic [3:0] set);
        return (cur & ~clr) | set;
    endfunction

    logic [`CAUSE_W-1:0] cause_reg, cause_next;
    logic [`CK_W-1:0] clk_reg, clk_next;
    logic [3:0] irq_stat_reg, irq_mask_reg;
    logic [15:0] rdata_next;
    logic pin_s1_reg, pin_s2_reg, pin_d_reg;
    logic ref_s1_reg, ref_s2_reg, ref_d_reg;
    logic [`FAIL_CNT_W-1:0] fail_cnt_reg;
    logic fail_reg;
    logic por_done_reg;

    wire wr_cause = wr_i && (addr_i == `OFF_CAUSE);
    wire wr_clk = wr_i && (addr_i == `OFF_CLK_CTRL);
    wire wr_stat = wr_i && (addr_i == `OFF_IRQ_STAT);
    wire wr_mask = wr_i && (addr_i == `OFF_IRQ_MASK);
    // master clear pin is active low after synchronising
    wire pin_fall = pin_d_reg && !pin_s2_reg;
    wire ref_edge = ref_s2_reg ^ ref_d_reg;
    wire fail_hit = !fail_reg && (fail_cnt_reg == `FAIL_CNT_W'(`FAIL_CYC));
    wire ev = event_valid_i;
    wire pin_ev = pin_fall || (ev && event_i == EV_PIN);
    wire is_por = ev && event_i == EV_POR;
    wire is_bor = ev && event_i == EV_BOR;
    wire clk_fail_ev = fail_hit || (ev && event_i == EV_CLK_FAIL);
    wire wake_ev = ev && is_wake_code(event_i);
    wire reset_ev = pin_ev || (ev && is_reset_code(event_i));
    // clock control write fields
    wire sw_now = wr_clk && wdata_i[`CK_SW];
    wire fail_clr = wr_clk && wdata_i[`CK_FAIL];
    wire [1:0] new_src = wdata_i[`CK_NEW_LO +: 2];
    wire load_config = is_por || is_bor || !por_done_reg;
    // irq status bits: 0 reset restart, 1 clock fail, 2 wake, 3 clock switch done
    wire [3:0] irq_set = {sw_now, wake_ev, clk_fail_ev, reset_ev};
    wire [3:0] irq_clr = wr_stat ? wdata_i[3:0] : 4'h0;
    wire [3:0] irq_mask_next = wr_mask ? wdata_i[3:0] : irq_mask_reg;
    wire [15:0] rdata_gate = rd_i ? rdata_next : 16'h0000;
    // an interrupt vector replaces pc plus 2 only when that interrupt is enabled
    wire wake_by_int = (event_i == EV_INT_WAKE) && int_enabled_i;
    wire [`PC_W-1:0] wake_pc = wake_by_int ? int_vector_i : pc_i + `PC_W'(2);

    // a simultaneous event overrides the software write; a pin fall outranks a core event in the same cycle
    always_comb begin
        cause_next = wr_cause ? wdata_i[`CAUSE_W-1:0] : cause_reg;
        if (pin_ev) begin
            cause_next[`F_PIN] = 1'b1;
            cause_next[`F_DOG] = 1'b0;
            unique case (power_state_i)
                PWR_SLEEP: begin
                    cause_next[`F_SLEEP] = 1'b1;
                    cause_next[`F_IDLE] = 1'b0;
                end
                PWR_IDLE: begin
                    cause_next[`F_IDLE] = 1'b1;
                    cause_next[`F_SLEEP] = 1'b0;
                end
                default: begin
                    cause_next[`F_SOFT] = 1'b0;
                    cause_next[`F_IDLE] = 1'b0;
                    cause_next[`F_SLEEP] = 1'b0;
                end
            endcase
        end else if (ev) begin
            unique case (event_i)
                EV_POR: begin
                    cause_next = '0;
                    cause_next[`F_POR] = 1'b1;
                    cause_next[`F_BOR] = 1'b1;
                end
                EV_BOR: begin
                    cause_next[`F_BOR] = 1'b1;
                    cause_next[`F_POR] = 1'b0;
                end
                EV_SOFT, EV_DOG_RESET: begin
                    cause_next[`F_SOFT] = (event_i == EV_SOFT);
                    cause_next[`F_DOG] = (event_i == EV_DOG_RESET);
                    cause_next[`F_PIN] = 1'b0;
                    cause_next[`F_IDLE] = 1'b0;
                    cause_next[`F_SLEEP] = 1'b0;
                end
                EV_DOG_WAKE: begin
                    cause_next[`F_DOG] = 1'b1;
                    cause_next[`F_SLEEP] = 1'b1;
                end
                EV_INT_WAKE: cause_next[`F_SLEEP] = 1'b1;
                EV_TRAP: cause_next[`F_TRAP] = 1'b1;
                EV_ILLOP: cause_next[`F_ILLOP] = 1'b1;
                default: cause_next = cause_next;
            endcase
        end
    end

    // clock control: power-on and brown-out take the configured source, software may switch later
    always_comb begin
        clk_next = clk_reg;
        if (wr_clk) begin
            clk_next[`CK_NEW_LO +: 2] = new_src;
            clk_next[`CK_POST_LO +: `POST_W] = wdata_i[`CK_POST_LO +: `POST_W];
            clk_next[`CK_PLL] = wdata_i[`CK_PLL];
        end
        if (sw_now) begin
            clk_next[`CK_SRC_LO +: 2] = new_src;
        end
        if (fail_clr) begin
            clk_next[`CK_FAIL] = 1'b0;
        end
        if (load_config) begin
            clk_next[`CK_SRC_LO +: 2] = config_src_i;
        end
        if (clk_fail_ev) begin
            clk_next[`CK_SRC_LO +: 2] = SRC_FAST_RC;
            clk_next[`CK_FAIL] = 1'b1;
        end
    end

    always_comb begin
        unique case (addr_i)
            `OFF_CAUSE: rdata_next = 16'(cause_reg);
            `OFF_CLK_CTRL: rdata_next = 16'(clk_reg);
            `OFF_IRQ_STAT: rdata_next = {12'h000, irq_stat_reg};
            `OFF_IRQ_MASK: rdata_next = {12'h000, irq_mask_reg};
            default: rdata_next = 16'h0000;
        endcase
    end

    // master clear pin: two flops, then one more to find the falling edge
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
            pin_d_reg <= 1'b1;
        end else begin
            pin_s1_reg <= master_clear_pin_i;
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg <= pin_s2_reg;
        end
    end

    // reference clock resets low, its parked level, so release gives no false edge
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ref_s1_reg <= 1'b0;
            ref_s2_reg <= 1'b0;
            ref_d_reg <= 1'b0;
        end else begin
            ref_s1_reg <= ref_clk_i;
            ref_s2_reg <= ref_s1_reg;
            ref_d_reg <= ref_s2_reg;
        end
    end

    // loss monitor: count system cycles between reference edges, latch once on timeout
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fail_cnt_reg <= '0;
            fail_reg <= 1'b0;
        end else if (ref_edge) begin
            fail_cnt_reg <= '0;
            fail_reg <= 1'b0;
        end else if (fail_hit) begin
            fail_reg <= 1'b1;
        end else if (!fail_reg) begin
            fail_cnt_reg <= fail_cnt_reg + `FAIL_CNT_W'(1);
        end
    end

    // power-on reset value of the cause register is the power-on pattern
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cause_reg <= `CAUSE_W'(9'h180);
        end else begin
            cause_reg <= cause_next;
        end
    end

    // por_done_reg stays low for the first edge so the configured source is loaded once
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clk_reg <= '0;
            por_done_reg <= 1'b0;
        end else begin
            clk_reg <= clk_next;
            por_done_reg <= 1'b1;
        end
    end

    // pending interrupt causes and their mask
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
        end else begin
            irq_stat_reg <= w1c_update(irq_stat_reg, irq_clr, irq_set);
            irq_mask_reg <= irq_mask_next;
        end
    end

    // read data stands only in the cycle after the strobe, so idle cycles show zero
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rdata_gate;
        end
    end

    // restart and trap pulses last one cycle each
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            restart_o <= 1'b0;
            clk_fail_trap_o <= 1'b0;
        end else begin
            restart_o <= reset_ev || wake_ev || clk_fail_ev;
            clk_fail_trap_o <= clk_fail_ev;
        end
    end

    // restart vector holds until the next event; reset outranks clock fail, which outranks wake
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            restart_pc_o <= `VEC_RESET;
        end else if (reset_ev) begin
            restart_pc_o <= `VEC_RESET;
        end else if (clk_fail_ev) begin
            restart_pc_o <= `VEC_CLKFAIL;
        end else if (wake_ev) begin
            restart_pc_o <= wake_pc;
        end
    end

    clk_postscale u_post (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .sel_i(clk_reg[`CK_POST_LO +: `POST_W]),
        .tick_o(sys_tick_o)
    );

    assign clk_src_o = clk_reg[`CK_SRC_LO +: 2];
    assign pll_en_o = clk_reg[`CK_PLL];
    assign irq_o = |(irq_stat_reg & irq_mask_reg);
endmodule

// ---- tb/reset_cause_props.sv ----
// reset_cause_props: concurrent checks on the restart vector, trap pulse and read port
// assumes ref_clk_i toggles except where a clock failure is meant
`timescale 1ns/100ps
`include "rcause_defines.svh"
module reset_cause_props (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire rcause_pkg::event_t event_i,
    input wire logic event_valid_i,
    input wire logic master_clear_pin_i,
    input wire logic [`PC_W-1:0] pc_i,
    input wire logic [`PC_W-1:0] int_vector_i,
    input wire logic int_enabled_i,
    input wire logic [`PC_W-1:0] restart_pc_o,
    input wire logic restart_o,
    input wire logic clk_fail_trap_o
);
    import rcause_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    wire rst_ev = event_valid_i && (event_i inside {EV_POR, EV_BOR, EV_SOFT, EV_DOG_RESET, EV_TRAP, EV_ILLOP});
    wire wake_ev = event_valid_i && event_i == EV_INT_WAKE;
    chk_reset_vector: assert property (rst_ev |=> restart_o && restart_pc_o == `VEC_RESET)
        else $error("reset event without restart at zero");
    chk_dog_wake: assert property (event_valid_i && event_i == EV_DOG_WAKE |=>
        restart_o && restart_pc_o == $past(pc_i) + 24'h000002) else $error("watchdog wake address");
    chk_int_vector: assert property (wake_ev && int_enabled_i |=>
        restart_pc_o == $past(int_vector_i)) else $error("interrupt wake vector");
    chk_int_plain: assert property (wake_ev && !int_enabled_i |=>
        restart_pc_o == $past(pc_i) + 24'h000002) else $error("plain wake address");
    chk_pin_restart: assert property ($fell(master_clear_pin_i) |->
        ##[1:6] (restart_o && restart_pc_o == `VEC_RESET)) else $error("pin reset without restart");
    chk_trap_vector: assert property (clk_fail_trap_o |->
        ##[0:1] (restart_o && restart_pc_o == `VEC_CLKFAIL)) else $error("clock fail vector");
    chk_trap_once: assert property (clk_fail_trap_o |=> !clk_fail_trap_o)
        else $error("clock fail trap longer than one cycle");
    chk_read_quiet: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read slot");
    cover property (rst_ev);
    cover property (wake_ev && int_enabled_i);
    cover property (clk_fail_trap_o);
endmodule
bind reset_cause_and_clock_select reset_cause_props i_chk (.*);

// ---- tb/reset_cause_and_clock_select_tb.sv ----
// reset_cause_and_clock_select_tb: register, event, pin and clock-fail sequences with fixed expectations
// assumes the checker binds itself; pc, vector and configured source are held constant
`timescale 1ns/100ps
`include "rcause_defines.svh"
module reset_cause_and_clock_select_tb;
    import rcause_pkg::*;
    logic clock_i, nrst_i, wr_i, rd_i, ev_valid, pin, int_en, ref_clk, ref_stop, restart, pll_en, tick, trap, irq, a;
    logic [3:0] addr;
    logic [15:0] wdata, rdata;
    logic [23:0] got, restart_pc;
    logic [1:0] clk_src;
    logic [2:0] ref_cnt;
    event_t ev;
    power_state_t ps;
    int failures, checked, cycles, n;
    // clock-fail code goes first so the later power-on and brown-out reload the configured source
    event_t evs [12] = '{EV_CLK_FAIL, EV_POR, EV_BOR, EV_SOFT, EV_DOG_RESET, EV_DOG_WAKE, EV_INT_WAKE, EV_TRAP,
        EV_ILLOP, EV_NONE, EV_NONE, EV_NONE};
    power_state_t pss [12] = '{PWR_RUN, PWR_RUN, PWR_RUN, PWR_RUN, PWR_RUN, PWR_SLEEP, PWR_SLEEP, PWR_RUN,
        PWR_RUN, PWR_RUN, PWR_SLEEP, PWR_IDLE};
    logic [11:0] pins = 12'hE00;
    logic [15:0] pre [12] = '{16'h0155, 16'h007F, 16'h00FF, 16'h01FF, 16'h01FF, 16'h0000, 16'h0000, 16'h0000,
        16'h01FC, 16'h01FF, 16'h01FF, 16'h01FF};
    logic [15:0] want [12] = '{16'h0155, 16'h0180, 16'h017F, 16'h018B, 16'h0193, 16'h0050, 16'h0040, 16'h0001,
        16'h01FE, 16'h0187, 16'h01CF, 16'h01AF};
    reset_cause_and_clock_select i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .event_i(ev), .event_valid_i(ev_valid), .power_state_i(ps),
        .master_clear_pin_i(pin), .pc_i(24'h0001F0), .int_vector_i(24'h000040), .int_enabled_i(int_en),
        .config_src_i(SRC_PRIMARY), .ref_clk_i(ref_clk), .restart_pc_o(restart_pc), .restart_o(restart),
        .clk_src_o(clk_src), .pll_en_o(pll_en), .sys_tick_o(tick), .clk_fail_trap_o(trap), .irq_o(irq));
    initial begin
        clock_i = 1'h0;
        forever #4 clock_i = ~clock_i;
    end
    // the reference runs at one eighth of the system clock and simply parks low when stopped
    always @(posedge clock_i) begin
        ref_cnt <= ref_cnt + 3'h1;
        ref_clk <= ref_cnt[2] & ~ref_stop;
        cycles++;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp_v);
        checked++;
        if (seen !== exp_v) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp_v);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [15:0] d);
        @(posedge clock_i);
        addr <= ad;
        wdata <= d;
        wr_i <= 1'h1;
        @(posedge clock_i);
        wr_i <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] ad);
        @(posedge clock_i);
        addr <= ad;
        rd_i <= 1'h1;
        @(posedge clock_i);
        rd_i <= 1'h0;
        #1 got = {8'h00, rdata};
    endtask
    task automatic fire(input event_t e, input power_state_t p, input logic by_pin);
        @(posedge clock_i);
        ps <= p;
        if (by_pin) begin
            pin <= 1'h0;
        end else begin
            ev <= e;
            ev_valid <= 1'h1;
        end
        @(posedge clock_i);
        ev_valid <= 1'h0;
        repeat (6) @(posedge clock_i);
        pin <= 1'h1;
    endtask
    task automatic give_verdict();
        if (failures == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        {nrst_i, wr_i, rd_i, ev_valid, int_en, ref_stop, ref_clk, ref_cnt, addr, wdata} = '0;
        {failures, checked, cycles, n} = '0;
        pin = 1'h1;
        ev = EV_NONE;
        ps = PWR_RUN;
        repeat (20) @(posedge clock_i);
        nrst_i <= 1'h1;
        rd(`OFF_CAUSE);
        check(got, 24'h000180);
        check({22'h0, clk_src}, 24'h000001);
        wr(`OFF_CLK_CTRL, 16'h0158);
        for (n = 0; n < 50 && clk_src !== SRC_SECONDARY; n++) @(posedge clock_i);
        check({22'h0, clk_src}, 24'h000002);
        check({23'h0, pll_en}, 24'h000001);
        n = 0;
        repeat (40) begin
            @(posedge clock_i);
            #1 n += tick;
        end
        check(24'(n), 24'h00000A);
        wr(4'hF, 16'hFFFF);
        rd(4'hF);
        check(got, 24'h000000);
        for (int i = 0; i < 12; i++) begin
            wr(`OFF_CAUSE, pre[i]);
            fire(evs[i], pss[i], pins[i]);
            rd(`OFF_CAUSE);
            check(got, {8'h00, want[i]});
        end
        check({22'h0, clk_src}, 24'h000001);
        int_en <= 1'h1;
        fire(EV_INT_WAKE, PWR_SLEEP, 1'h0);
        check(restart_pc, 24'h000040);
        int_en <= 1'h0;
        wr(`OFF_IRQ_MASK, 16'h0000);
        rd(`OFF_IRQ_STAT);
        check(got & 24'h000003, 24'h000003);
        a = irq;
        wr(`OFF_IRQ_MASK, 16'h000F);
        #1 check({23'h0, irq ^ a}, 24'h000001);
        wr(`OFF_IRQ_STAT, 16'h000F);
        rd(`OFF_IRQ_STAT);
        check(got, 24'h000000);
        check({23'h0, irq}, 24'h000000);
        wr(`OFF_CAUSE, 16'h00AA);
        ref_stop <= 1'h1;
        for (n = 0; n < 300 && trap !== 1'h1; n++) begin
            @(posedge clock_i);
            #1;
        end
        check({23'h0, n >= 110 && n < 300}, 24'h000001);
        @(posedge clock_i);
        ref_stop <= 1'h0;
        check({22'h0, clk_src}, 24'h000000);
        rd(`OFF_CAUSE);
        check(got, 24'h0000AA);
        rd(`OFF_CLK_CTRL);
        check(got & 24'h000200, 24'h000200);
        give_verdict();
    end
endmodule
